// ---- lcd_cfg_pkg.sv ----
// Functional notes
// - Raw and masked status views; masked shows only enabled sources.
// - Completion flag set when character-bus DMA transfer finishes.
// - Frame-done flag set each time a raster frame is fully output.
// - Sync-lost flag set whenever frame synchronization is lost.
// - AC bias counter at zero: raise flag, reload, hold until flag cleared.
// - Underflow flag set when output needs data and FIFO is empty.
// - Palette-loaded flag set once palette reaches internal palette RAM.
// - Separate end-of-frame flags for frame buffer 0 and frame buffer 1.
// - Mode selector: asynchronous character bus or synchronous raster video.
// - Auto underflow restart lets hardware restart output after underflow.
// - Integer clock divisor: 1..255 character bus, 2..255 raster.
// - Integer ratios only; produced rate never exceeds requested rate.
// - AC bias count 0..15 transitions; zero suppresses that interrupt.
// - Programmable wait cycles after each 16-halfword palette burst.
// - Active direct formats: packed 24, unpacked 24, 16-bit.
// - Active palettized 1/2/4/8 bpp output as 12-bit or 5:6:5.
// - Passive: mono 4 or 8 pixels, 12-bit bypass, 5:6:5 top four bits.
// - Option keeps active video toggling during vertical blanking.
// - Nibble mode byte-swaps fetched words before 1/2/4 bit extraction.
// - Load control: data only reuses palette, palette only fetches palette.
// - Reversed order takes leftmost pixel from MSBs, else from LSBs.
// - Disabled raster finishes current frame, then signals frame done.
package lcd_cfg_pkg;

    localparam logic [11:0] OFS_MODE_CTRL  = 12'h0_000;
    localparam logic [11:0] OFS_RASTER_CFG = 12'h0_004;
    localparam logic [11:0] OFS_ACB_COUNT  = 12'h0_008;
    localparam logic [11:0] OFS_INT_EN     = 12'h0_00C;
    localparam logic [11:0] OFS_INT_RAW    = 12'h0_010;
    localparam logic [11:0] OFS_INT_MASKED = 12'h0_014;
    localparam logic [11:0] OFS_STATUS     = 12'h0_018;

    // Mode control fields
    localparam int MC_MODE    = 0;
    localparam int MC_AUTORST = 1;
    localparam int MC_DIV_LO  = 8;
    localparam int MC_RAS_EN  = 16;
    // Raster config fields
    localparam int RC_FMT_LO   = 0;
    localparam int RC_ACTVID   = 4;
    localparam int RC_NIBBLE   = 5;
    localparam int RC_DATA_ONL = 6;
    localparam int RC_PAL_ONL  = 7;
    localparam int RC_MSB1ST   = 8;
    localparam int RC_PDLY_LO  = 16;
    // Status fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_ACB_HL = 1;
    localparam int ST_DIV_LO = 8;

    // Interrupt flag positions
    localparam int IRQ_DMA_DONE  = 0;
    localparam int IRQ_FRM_DONE  = 1;
    localparam int IRQ_SYNC_LOST = 2;
    localparam int IRQ_ACB       = 3;
    localparam int IRQ_UNDERFLOW = 4;
    localparam int IRQ_PAL_LOAD  = 5;
    localparam int IRQ_EOF0      = 6;
    localparam int IRQ_EOF1      = 7;

    // Panel formats
    localparam logic [3:0] FMT_ACT_24P   = 4'h0;
    localparam logic [3:0] FMT_ACT_24U   = 4'h1;
    localparam logic [3:0] FMT_ACT_16    = 4'h2;
    localparam logic [3:0] FMT_ACT_PAL12 = 4'h3;
    localparam logic [3:0] FMT_ACT_PAL16 = 4'h4;
    localparam logic [3:0] FMT_PAS_MONO4 = 4'h5;
    localparam logic [3:0] FMT_PAS_MONO8 = 4'h6;
    localparam logic [3:0] FMT_PAS_C12   = 4'h7;
    localparam logic [3:0] FMT_PAS_C16   = 4'h8;

    // Frame-buffer bit depth codes
    localparam logic [1:0] BPP_1 = 2'h0;
    localparam logic [1:0] BPP_2 = 2'h1;
    localparam logic [1:0] BPP_4 = 2'h2;
    localparam logic [1:0] BPP_8 = 2'h3;

    localparam logic [7:0] DIV_MAX        = 8'h0_0FF;
    localparam logic [7:0] DIV_MIN_CHAR   = 8'h0_001;
    localparam logic [7:0] DIV_MIN_RASTER = 8'h0_002;
    localparam logic [7:0] DIV_RESET      = 8'h0_002;
    localparam logic [3:0] PAL_BURST_LAST = 4'h0_00F;
    localparam logic [7:0] PDLY_RESET     = 8'h0_000;
    localparam logic [3:0] ACB_RESET      = 4'h0_000;
    localparam logic [7:0] INT_EN_RESET   = 8'h0_000;
    localparam logic [3:0] FMT_RESET      = FMT_ACT_16;

endpackage : lcd_cfg_pkg

// ---- lcd_div_if.sv ----
`timescale 1ns/1ns
interface lcd_div_if;
    logic [7:0] divisor;
    logic       raster;
    logic       tick;
    logic       clk_lvl;
    modport ctrl (output divisor, output raster, input tick, input clk_lvl);
    modport gen  (input divisor, input raster, output tick, output clk_lvl);
endinterface : lcd_div_if

// ---- lcd_clk_div.sv ----
`timescale 1ns/1ns
module lcd_clk_div
    import lcd_cfg_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    lcd_div_if.gen    div
);
    import lcd_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
        logic       lvl;
    } div_state_t;

    div_state_t s_r;
    div_state_t s_nxt;
    logic [7:0] eff_div;

    always_comb begin
        // Clamp into legal range; integer ratio never speeds the clock up
        eff_div = div.divisor;
        if (div.raster && eff_div < DIV_MIN_RASTER) begin
            eff_div = DIV_MIN_RASTER;
        end else if (!div.raster && eff_div < DIV_MIN_CHAR) begin
            eff_div = DIV_MIN_CHAR;
        end
        s_nxt = s_r;
        if (s_r.cnt >= eff_div - 8'h0_001) begin
            s_nxt.cnt = 8'h0_000;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h0_001;
        end
        s_nxt.tick = (s_nxt.cnt == 8'h0_000);
        s_nxt.lvl  = ({1'b0, s_nxt.cnt} < (({1'b0, eff_div} + 9'h0_001) >> 1));
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign div.tick    = s_r.tick;
    assign div.clk_lvl = s_r.lvl;

endmodule : lcd_clk_div

// ---- lcd_raster_cfg.sv ----
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
module lcd_raster_cfg
    import lcd_cfg_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Engine events, one-cycle pulses
    input  wire logic        dma_done_evt,
    input  wire logic        frame_end_evt,
    input  wire logic        sync_lost_evt,
    input  wire logic        underflow_evt,
    input  wire logic        palette_done_evt,
    input  wire logic        eof0_evt,
    input  wire logic        eof1_evt,
    input  wire logic        ac_bias_edge,
    input  wire logic        pal_halfword,
    // Pixel extraction request
    input  wire logic        pix_req,
    input  wire logic [31:0] fb_word,
    input  wire logic [1:0]  fb_bpp,
    input  wire logic [4:0]  pix_index,
    // Configuration toward the engine and panel
    output logic             raster_video_mode,
    output logic             raster_active,
    output logic             restart_pulse,
    output logic [3:0]       panel_format,
    output logic             passive_panel,
    output logic             palette_lookup,
    output logic             out_12bit,
    output logic             gray_msb4,
    output logic [3:0]       mono_pix_per_clk,
    output logic             actvid_in_blank,
    output logic             fetch_pixels,
    output logic             fetch_palette,
    output logic             pal_wait,
    output logic [7:0]       pix_data,
    output logic             pix_valid,
    output logic             lcd_clk,
    output logic             lcd_clk_tick
);
    import lcd_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        mode;
        logic        auto_rst;
        logic [7:0]  div;
        logic        ras_en;
        logic [3:0]  fmt;
        logic        actvid;
        logic        nibble;
        logic        fetch_pal;
        logic        fetch_pix;
        logic        msb_first;
        logic [7:0]  pal_delay;
        logic [3:0]  acb_count;
        logic [7:0]  int_en;
        logic [7:0]  raw;
        logic        active;
        logic [3:0]  acb_cnt;
        logic        acb_halt;
        logic [3:0]  hw_cnt;
        logic [7:0]  wait_cnt;
        logic        wait_on;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        restart;
        logic [7:0]  pix;
        logic        pix_valid;
    } cfg_state_t;

    cfg_state_t s_r;
    cfg_state_t s_nxt;
    lcd_div_if  div_bus ();

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic is_passive(input logic [3:0] f);
        is_passive = (f >= FMT_PAS_MONO4);
    endfunction : is_passive

    function automatic logic [7:0] pick_pixel(
        input logic [31:0] w,
        input logic [1:0]  bpp,
        input logic [4:0]  idx,
        input logic        swap,
        input logic        msb1st
    );
        logic [31:0] ww;
        logic [5:0]  bits;
        logic [5:0]  sh;
        logic [7:0]  mask;
        ww   = w;
        bits = 6'd1 << bpp;
        mask = 8'h0_0FF >> (4'd8 - 4'(bits));
        if (swap && bpp != BPP_8) begin
            ww = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
        if (msb1st) begin
            sh = 6'd32 - 6'(({1'b0, idx} + 6'd1) << bpp);
        end else begin
            sh = 6'({1'b0, idx} << bpp);
        end
        pick_pixel = 8'(ww >> sh) & mask;
    endfunction : pick_pixel

    function automatic logic set_clr(input logic cur, input logic set, input logic clr);
        // Set wins over a clear in the same cycle
        set_clr = set | (cur & ~clr);
    endfunction : set_clr

    ////////////////////////////////////////////////////////////////////////////
    logic       acc;
    logic       wr;
    logic       fmt_wr;
    logic [7:0] evt;
    logic [7:0] clr;
    logic       acb_zero;

    always_comb begin
        s_nxt    = s_r;
        acc      = psel && penable && !s_r.pready;
        wr       = acc && pwrite;
        fmt_wr   = 1'b0;
        clr      = 8'h0_000;
        evt      = 8'h0_000;
        acb_zero = 1'b0;

        // Bus access with one wait state
        s_nxt.pready  = acc;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0000_0000;
        if (acc) begin
            unique case (paddr)
                OFS_MODE_CTRL: begin
                    s_nxt.prdata[MC_MODE]            = s_r.mode;
                    s_nxt.prdata[MC_AUTORST]         = s_r.auto_rst;
                    s_nxt.prdata[MC_DIV_LO +: 8]     = s_r.div;
                    s_nxt.prdata[MC_RAS_EN]          = s_r.ras_en;
                end
                OFS_RASTER_CFG: begin
                    s_nxt.prdata[RC_FMT_LO +: 4]     = s_r.fmt;
                    s_nxt.prdata[RC_ACTVID]          = s_r.actvid;
                    s_nxt.prdata[RC_NIBBLE]          = s_r.nibble;
                    s_nxt.prdata[RC_DATA_ONL]        = !s_r.fetch_pal;
                    s_nxt.prdata[RC_PAL_ONL]         = !s_r.fetch_pix;
                    s_nxt.prdata[RC_MSB1ST]          = s_r.msb_first;
                    s_nxt.prdata[RC_PDLY_LO +: 8]    = s_r.pal_delay;
                end
                OFS_ACB_COUNT:  s_nxt.prdata[3:0] = s_r.acb_count;
                OFS_INT_EN:     s_nxt.prdata[7:0] = s_r.int_en;
                OFS_INT_RAW:    s_nxt.prdata[7:0] = s_r.raw;
                OFS_INT_MASKED: s_nxt.prdata[7:0] = s_r.raw & s_r.int_en;
                OFS_STATUS: begin
                    s_nxt.prdata[ST_ACTIVE]          = s_r.active;
                    s_nxt.prdata[ST_ACB_HL]          = s_r.acb_halt;
                    s_nxt.prdata[ST_DIV_LO +: 8]     = s_r.div;
                end
                default:        s_nxt.pslverr = 1'b1;
            endcase
        end

        // Register writes
        if (wr) begin
            unique case (paddr)
                OFS_MODE_CTRL: begin
                    s_nxt.mode     = pwdata[MC_MODE];
                    s_nxt.auto_rst = pwdata[MC_AUTORST];
                    s_nxt.div      = pwdata[MC_DIV_LO +: 8];
                    s_nxt.ras_en   = pwdata[MC_RAS_EN];
                end
                OFS_RASTER_CFG: begin
                    fmt_wr          = 1'b1;
                    s_nxt.fmt       = pwdata[RC_FMT_LO +: 4];
                    s_nxt.actvid    = pwdata[RC_ACTVID];
                    s_nxt.nibble    = pwdata[RC_NIBBLE];
                    s_nxt.fetch_pal = !pwdata[RC_DATA_ONL];
                    s_nxt.fetch_pix = !pwdata[RC_PAL_ONL];
                    s_nxt.msb_first = pwdata[RC_MSB1ST];
                    s_nxt.pal_delay = pwdata[RC_PDLY_LO +: 8];
                end
                OFS_ACB_COUNT: begin
                    s_nxt.acb_count = pwdata[3:0];
                    s_nxt.acb_cnt   = pwdata[3:0];
                end
                OFS_INT_EN:    s_nxt.int_en = pwdata[7:0];
                OFS_INT_RAW:   clr          = pwdata[7:0];
                default:       s_nxt.pslverr = s_nxt.pslverr;
            endcase
        end
        // Reconfiguring the panel drops the raster enable
        if (fmt_wr) begin
            s_nxt.ras_en = 1'b0;
        end

        // AC bias transition counter, passive panels only
        if (ac_bias_edge && s_r.mode && is_passive(s_r.fmt)
            && s_r.acb_count != 4'h0_000 && !s_r.acb_halt) begin
            if (s_r.acb_cnt <= 4'h0_001) begin
                acb_zero       = 1'b1;
                s_nxt.acb_cnt  = s_r.acb_count;
                s_nxt.acb_halt = 1'b1;
            end else begin
                s_nxt.acb_cnt = s_r.acb_cnt - 4'h0_001;
            end
        end
        if (clr[IRQ_ACB] && !acb_zero) begin
            s_nxt.acb_halt = 1'b0;
        end

        // Event collection
        evt[IRQ_DMA_DONE]  = dma_done_evt && !s_r.mode;
        evt[IRQ_FRM_DONE]  = frame_end_evt && s_r.mode && s_r.active;
        evt[IRQ_SYNC_LOST] = sync_lost_evt;
        evt[IRQ_ACB]       = acb_zero;
        evt[IRQ_UNDERFLOW] = underflow_evt;
        evt[IRQ_PAL_LOAD]  = palette_done_evt;
        evt[IRQ_EOF0]      = eof0_evt;
        evt[IRQ_EOF1]      = eof1_evt;
        for (int i = 0; i < 8; i++) begin
            s_nxt.raw[i] = set_clr(s_r.raw[i], evt[i], clr[i]);
        end

        // Underflow handling
        s_nxt.restart = 1'b0;
        if (underflow_evt && s_r.active) begin
            if (s_r.auto_rst) begin
                s_nxt.restart = 1'b1;
            end else begin
                s_nxt.ras_en = 1'b0;
            end
        end

        // Raster runs on until the frame in flight ends
        if (s_nxt.ras_en && s_nxt.mode) begin
            s_nxt.active = 1'b1;
        end else if (frame_end_evt) begin
            s_nxt.active = 1'b0;
        end

        // Palette burst pacing
        if (s_r.wait_cnt != 8'h0_000) begin
            s_nxt.wait_cnt = s_r.wait_cnt - 8'h0_001;
        end else if (pal_halfword) begin
            s_nxt.hw_cnt = s_r.hw_cnt + 4'h0_001;
            if (s_r.hw_cnt == PAL_BURST_LAST) begin
                s_nxt.wait_cnt = s_r.pal_delay;
            end
        end
        s_nxt.wait_on = (s_nxt.wait_cnt != 8'h0_000);

        // Pixel extraction for 1/2/4/8 bpp frame buffers
        s_nxt.pix_valid = pix_req;
        if (pix_req) begin
            s_nxt.pix = pick_pixel(fb_word, fb_bpp, pix_index, s_r.nibble, s_r.msb_first);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r           <= '0;
            s_r.div       <= DIV_RESET;
            s_r.fmt       <= FMT_RESET;
            s_r.pal_delay <= PDLY_RESET;
            s_r.acb_count <= ACB_RESET;
            s_r.acb_cnt   <= ACB_RESET;
            s_r.int_en    <= INT_EN_RESET;
            s_r.fetch_pix <= 1'b1;
            s_r.fetch_pal <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign div_bus.divisor = s_r.div;
    assign div_bus.raster  = s_r.mode;

    lcd_clk_div u_clk_div (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .div     (div_bus.gen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Format decode registered for the panel side
    typedef struct packed {
        logic       passive;
        logic       lookup;
        logic       b12;
        logic       msb4;
        logic [3:0] mono;
    } fmt_dec_t;

    fmt_dec_t f_r;
    fmt_dec_t f_nxt;

    always_comb begin
        f_nxt.passive = is_passive(s_nxt.fmt);
        f_nxt.lookup  = (s_nxt.fmt == FMT_ACT_PAL12) || (s_nxt.fmt == FMT_ACT_PAL16)
                     || (s_nxt.fmt == FMT_PAS_MONO4) || (s_nxt.fmt == FMT_PAS_MONO8);
        f_nxt.b12     = (s_nxt.fmt == FMT_ACT_PAL12);
        f_nxt.msb4    = (s_nxt.fmt == FMT_PAS_C16);
        unique case (s_nxt.fmt)
            FMT_PAS_MONO4: f_nxt.mono = 4'h0_004;
            FMT_PAS_MONO8: f_nxt.mono = 4'h0_008;
            default:       f_nxt.mono = 4'h0_000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            f_r <= '0;
        end else begin
            f_r <= f_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata            = s_r.prdata;
    assign pready            = s_r.pready;
    assign pslverr           = s_r.pslverr;
    assign raster_video_mode = s_r.mode;
    assign raster_active     = s_r.active;
    assign restart_pulse     = s_r.restart;
    assign panel_format      = s_r.fmt;
    assign passive_panel     = f_r.passive;
    assign palette_lookup    = f_r.lookup;
    assign out_12bit         = f_r.b12;
    assign gray_msb4         = f_r.msb4;
    assign mono_pix_per_clk  = f_r.mono;
    assign actvid_in_blank   = s_r.actvid;
    assign fetch_pixels      = s_r.fetch_pix;
    assign fetch_palette     = s_r.fetch_pal;
    assign pal_wait          = s_r.wait_on;
    assign pix_data          = s_r.pix;
    assign pix_valid         = s_r.pix_valid;
    assign lcd_clk           = div_bus.clk_lvl;
    assign lcd_clk_tick      = div_bus.tick;

endmodule : lcd_raster_cfg

// ---- lcd_cfg_assertions.sv ----
`timescale 1ns/1ns
module lcd_cfg_assertions
    import lcd_cfg_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       pix_req,
    input wire logic       pix_valid,
    input wire logic       lcd_clk_tick,
    input wire logic       raster_video_mode,
    input wire logic       raster_active,
    input wire logic       frame_end_evt,
    input wire logic [3:0] panel_format,
    input wire logic       palette_lookup,
    input wire logic       out_12bit,
    input wire logic       passive_panel,
    input wire logic [3:0] mono_pix_per_clk,
    input wire logic       gray_msb4,
    input wire logic       pal_wait,
    input wire logic       pal_halfword
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_raster_div_two: assert property (
        raster_video_mode && $past(raster_video_mode, 2) && lcd_clk_tick |=> !lcd_clk_tick)
        else $error("raster tick on back to back cycles");
    a_pal12_decode: assert property (panel_format == FMT_ACT_PAL12 |-> palette_lookup && out_12bit)
        else $error("pal12 decode wrong");
    a_mono8_decode: assert property (
        panel_format == FMT_PAS_MONO8 |-> passive_panel && mono_pix_per_clk == 4'h8)
        else $error("mono8 decode wrong");
    a_c16_gray_bits: assert property (panel_format == FMT_PAS_C16 |-> gray_msb4 && !palette_lookup)
        else $error("c16 decode wrong");
    a_pal_wait_start: assert property ($rose(pal_wait) |-> $past(pal_halfword))
        else $error("palette wait without halfword");
    a_stop_at_frame: assert property (
        $fell(raster_active) && raster_video_mode |-> $past(frame_end_evt))
        else $error("raster stopped mid frame");
    a_pix_answer: assert property (pix_valid == $past(pix_req))
        else $error("pix_valid not one cycle after pix_req");
endmodule : lcd_cfg_assertions

bind lcd_raster_cfg lcd_cfg_assertions chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .pix_req(pix_req), .pix_valid(pix_valid),
    .lcd_clk_tick(lcd_clk_tick), .raster_video_mode(raster_video_mode), .raster_active(raster_active),
    .frame_end_evt(frame_end_evt), .panel_format(panel_format), .palette_lookup(palette_lookup),
    .out_12bit(out_12bit), .passive_panel(passive_panel), .mono_pix_per_clk(mono_pix_per_clk),
    .gray_msb4(gray_msb4), .pal_wait(pal_wait), .pal_halfword(pal_halfword));

// ---- panel_model.sv ----
`timescale 1ns/1ns
module panel_model (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic lcd_clk_tick,
    output int        tick_cnt
);
    // Panel takes one sample per divided clock period
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) tick_cnt <= 0;
        else if (lcd_clk_tick) tick_cnt <= tick_cnt + 1;
    end
endmodule : panel_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    import lcd_cfg_pkg::*;
    typedef struct packed {logic [31:0] m; logic [8:0] e; logic [31:0] x;} row_t;
    localparam logic [31:0] M_R = 32'h0001_0201;
    logic        ref_clk = 0;
    logic        rst_b, psel, penable, pwrite, pix_req, pslverr, pready, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fb_word, rd;
    logic [8:0]  ev;
    logic [1:0]  fb_bpp;
    logic [4:0]  pix_index;
    logic [7:0]  pix_data;
    logic [3:0]  panel_format;
    logic        rvm, ract, rst_p, f_pix, f_pal, pal_wait, pix_valid, tick, av, lck;
    int          n, t0, cyc, tick_cnt, checks_done, n_mismatch;
    row_t        rows [8] = '{'{32'h0000_0200, 9'h001, 32'h0000_0001}, '{M_R, 9'h002, 32'h0000_0002},
        '{M_R, 9'h004, 32'h0000_0004}, '{M_R, 9'h010, 32'h0000_0020}, '{M_R, 9'h020, 32'h0000_0040},
        '{M_R, 9'h040, 32'h0000_0080}, '{M_R, 9'h008, 32'h0000_0010}, '{M_R, 9'h001, 32'h0000_0000}};
    always #20 ref_clk = ~ref_clk;
    lcd_raster_cfg uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma_done_evt(ev[0]), .frame_end_evt(ev[1]), .sync_lost_evt(ev[2]), .underflow_evt(ev[3]),
        .palette_done_evt(ev[4]), .eof0_evt(ev[5]), .eof1_evt(ev[6]), .ac_bias_edge(ev[7]),
        .pal_halfword(ev[8]), .pix_req(pix_req), .fb_word(fb_word), .fb_bpp(fb_bpp), .pix_index(pix_index),
        .raster_video_mode(rvm), .raster_active(ract), .restart_pulse(rst_p), .panel_format(panel_format),
        .passive_panel(), .palette_lookup(), .out_12bit(), .gray_msb4(), .mono_pix_per_clk(),
        .actvid_in_blank(av), .fetch_pixels(f_pix), .fetch_palette(f_pal), .pal_wait(pal_wait),
        .pix_data(pix_data), .pix_valid(pix_valid), .lcd_clk(lck), .lcd_clk_tick(tick));
    panel_model pm (.ref_clk(ref_clk), .rst_b(rst_b), .lcd_clk_tick(tick), .tick_cnt(tick_cnt));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask : apb
    task pulse(input logic [8:0] e);
        ev <= e;
        @(posedge ref_clk) ev <= 0;
        @(posedge ref_clk);
    endtask : pulse
    task ck(input logic [31:0] m, input int w, input logic [31:0] e);
        apb(1, OFS_MODE_CTRL, m);
        repeat (260) @(posedge ref_clk);
        t0 = tick_cnt; n = 0;
        repeat (w) @(posedge ref_clk) n += lck;
        chk(tick_cnt - t0, e);
        chk((n > 0 && n < w) != (e == w), 1);
    endtask : ck
    task px(input logic [31:0] c, input logic [1:0] b, input logic [4:0] i, input logic [7:0] e);
        apb(1, OFS_RASTER_CFG, c);
        fb_word <= 32'h1234_5678; fb_bpp <= b; pix_index <= i; pix_req <= 1;
        @(posedge ref_clk) pix_req <= 0;
        @(posedge ref_clk);
        chk(pix_valid, 1);
        chk(pix_data, e);
    endtask : px
    task final_report;
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin n_mismatch++; final_report(); end
    end
    initial begin
        rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ev = 0;
        pix_req = 0; fb_word = 0; fb_bpp = 0; pix_index = 0; cyc = 0; checks_done = 0; n_mismatch = 0;
        repeat (2) @(posedge ref_clk);
        chk({f_pix, f_pal, ract}, 3'b110);
        repeat (3) @(posedge ref_clk);
        rst_b <= 1;
        @(posedge ref_clk);
        apb(0, OFS_MODE_CTRL, 0); chk(rd, 32'h0000_0200);
        apb(0, 12'h01C, 0); chk(er, 1); chk(rd, 0);
        foreach (rows[k]) begin
            apb(1, OFS_MODE_CTRL, rows[k].m); pulse(rows[k].e);
            apb(0, OFS_INT_RAW, 0); chk(rd, rows[k].x);
            apb(1, OFS_INT_RAW, 32'h0000_00FF); apb(0, OFS_INT_RAW, 0); chk(rd, 0);
        end
        apb(1, OFS_INT_EN, 32'h0000_0002); apb(1, OFS_MODE_CTRL, M_R); pulse(9'h006);
        apb(0, OFS_INT_MASKED, 0); chk(rd, 32'h0000_0002);
        apb(0, OFS_INT_RAW, 0); chk(rd, 32'h0000_0006);
        apb(1, OFS_INT_RAW, 32'h0000_00FF); apb(1, OFS_INT_EN, 0);
        apb(1, OFS_RASTER_CFG, 32'h0000_0005); apb(0, OFS_MODE_CTRL, 0); chk(rd, 32'h0000_0201);
        apb(1, OFS_MODE_CTRL, M_R); apb(1, OFS_ACB_COUNT, 3); pulse(9'h080); pulse(9'h080);
        apb(0, OFS_INT_RAW, 0); chk(rd, 0);
        pulse(9'h080); apb(0, OFS_INT_RAW, 0); chk(rd, 32'h0000_0008);
        apb(0, OFS_STATUS, 0); chk(rd, 32'h0000_0203);
        apb(1, OFS_ACB_COUNT, 0); apb(1, OFS_INT_RAW, 32'h0000_00FF);
        repeat (4) pulse(9'h080);
        apb(0, OFS_INT_RAW, 0); chk(rd, 0);
        for (int f = 0; f < 9; f++) begin
            apb(1, OFS_RASTER_CFG, f); chk(panel_format, f);
        end
        apb(1, OFS_RASTER_CFG, 32'h0000_0052); chk({f_pix, f_pal}, 2'b10); chk(av, 1);
        apb(1, OFS_RASTER_CFG, 32'h0000_0082); chk({f_pix, f_pal, av}, 3'b010);
        px(32'h0000_0004, BPP_4, 0, 8'h08); px(32'h0000_0104, BPP_4, 0, 8'h01);
        px(32'h0000_0024, BPP_4, 0, 8'h02); px(32'h0000_0124, BPP_4, 0, 8'h07);
        px(32'h0000_0024, BPP_8, 1, 8'h56);
        apb(1, OFS_RASTER_CFG, 32'h0003_0002);
        repeat (15) pulse(9'h100);
        ev <= 9'h100; n = 0;
        @(posedge ref_clk) ev <= 0;
        repeat (8) @(posedge ref_clk) n += pal_wait;
        chk(n, 3);
        ck(32'h0000_0100, 40, 40); ck(32'h0000_0500, 40, 8); ck(32'h0000_0101, 40, 20); ck(32'h0000_FF01, 510, 2);
        apb(1, OFS_MODE_CTRL, 32'h0001_0203);
        ev <= 9'h008; n = 0;
        repeat (5) @(posedge ref_clk) begin ev <= 0; n += rst_p; end
        chk(n, 1);
        apb(0, OFS_MODE_CTRL, 0); chk(rd, 32'h0001_0203);
        apb(1, OFS_INT_RAW, 32'h0000_00FF); apb(1, OFS_MODE_CTRL, 32'h0000_0201);
        repeat (4) @(posedge ref_clk);
        chk({rvm, ract}, 2'b11);
        pulse(9'h002); chk(ract, 0);
        apb(0, OFS_INT_RAW, 0); chk(rd, 32'h0000_0002);
        final_report();
    end
endmodule : tb
